//--- rtl/mtc_cfg.svh
// Constants of the channel-0 timer control block.
// Assumes one system clock and an 8-bit register port.
// Summary of operation
// - Phase flag puts channel 2 into phase counting
// - Pair field sets channels 3/4 combined mode
// - Clock field picks divided clock or pin
// - Edge field picks rising, falling or both
// - Clear code 01 clears on A; 00 never
// - Clear code 10 clears on B event
// - Clear code 11 clears with synchronized timers
// - A output compare drives none, 0, 1, toggle
// - A capture on rising, falling or both edges
// - B output compare drives none, 0, 1, toggle
// - B capture on rising, falling or both edges
// - A match interrupt passes only when enabled
// - B match interrupt passes only when enabled
// - Overflow interrupt passes only when enabled
`ifndef MTC_CFG_SVH
`define MTC_CFG_SVH
// =====================================
// Register offsets
`define MTC_START_OFS   8'h60
`define MTC_SYNC_OFS    8'h61
`define MTC_MODE_OFS    8'h62
`define MTC_FUNC_OFS    8'h63
`define MTC_CTRL_OFS    8'h64
`define MTC_PIO_OFS     8'h65
`define MTC_IEN_OFS     8'h66
`define MTC_STAT_OFS    8'h67
`define MTC_CNTH_OFS    8'h68
`define MTC_CNTL_OFS    8'h69
`define MTC_GRAH_OFS    8'h6a
`define MTC_GRAL_OFS    8'h6b
`define MTC_GRBH_OFS    8'h6c
`define MTC_GRBL_OFS    8'h6d
// =====================================
// Field positions
`define MTC_CH0_BIT     0
`define MTC_CH4_BIT     4
`define MTC_PHASE_BIT   6
`define MTC_PAIR_HI     5
`define MTC_PAIR_LO     4
`define MTC_CLR_HI      6
`define MTC_CLR_LO      5
`define MTC_EDGE_HI     4
`define MTC_EDGE_LO     3
`define MTC_SRC_HI      2
`define MTC_SRC_LO      0
`define MTC_IOB_HI      6
`define MTC_IOB_LO      4
`define MTC_IOA_HI      2
`define MTC_IOA_LO      0
// =====================================
// Reset values and fixed read bits
`define MTC_CTRL_FIX    8'h80
`define MTC_PIO_FIX     8'h88
`define MTC_IEN_FIX     8'hf8
`define MTC_STAT_FIX    8'hf8
`define MTC_CNT_MAX     16'hffff
`endif

//--- rtl/mtc_pkg.sv
// Types shared by the channel-0 timer control block.
// Assumes the constants of mtc_cfg.svh.
package mtc_pkg;
  // =====================================
  // Counter clear source
  typedef enum logic [1:0] {
    MTC_CLR_NONE = 2'h0,
    MTC_CLR_A    = 2'h1,
    MTC_CLR_B    = 2'h2,
    MTC_CLR_SYNC = 2'h3
  } mtc_clr_t;
  // =====================================
  // Channels 3 and 4 pairing
  typedef enum logic [1:0] {
    MTC_PAIR_IND0 = 2'h0,
    MTC_PAIR_IND1 = 2'h1,
    MTC_PAIR_CPWM = 2'h2,
    MTC_PAIR_RPWM = 2'h3
  } mtc_pair_t;
endpackage

//--- rtl/mtc_top.sv
// Channel-0 timer with shared start, sync, mode and pairing control.
// Assumes synchronous pins and a one-cycle register port.
`timescale 1ns/1ps
`include "mtc_cfg.svh"
module mtc_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rdata_q,
  // External count clocks a..d
  input  wire logic [3:0]  ext_clock_pin,
  // Pin A, two-way
  input  wire logic        pin_a_in,
  output logic             pin_a_out_q,
  output logic             pin_a_oe_q,
  // Pin B, two-way
  input  wire logic        pin_b_in,
  output logic             pin_b_out_q,
  output logic             pin_b_oe_q,
  // Synchronous clear between channels
  input  wire logic        sync_clear_in,
  output logic             sync_clear_out_q,
  // Settings for other channels
  output logic             ch2_phase_mode_q,
  output mtc_pkg::mtc_pair_t pair_combination_mode_q,
  output logic             channel4_sync_q,
  output logic [4:0]       start_q,
  // Interrupt
  output logic             irq_q
);
  // =====================================
  // Registers
  logic [7:0]  start_reg_q;
  logic [7:0]  sync_reg_q;
  logic [7:0]  mode_reg_q;
  logic [7:0]  func_reg_q;
  logic [6:0]  tcr_q;
  logic [2:0]  pin_control_a;
  logic [2:0]  pin_control_b;
  logic [2:0]  ien_q;
  logic [2:0]  st_q;
  logic [15:0] count_register;
  logic [15:0] general_reg_a;
  logic [15:0] general_reg_b;
  logic [2:0]  presc_q;
  logic [3:0]  ext_prev_q;
  logic        pa_prev_q;
  logic        pb_prev_q;
  // =====================================
  // Decoded fields
  logic [2:0]        clock_source_select;
  logic [1:0]        external_edge_select;
  mtc_pkg::mtc_clr_t clear_source_select;
  assign clock_source_select  = tcr_q[`MTC_SRC_HI:`MTC_SRC_LO];
  assign external_edge_select = tcr_q[`MTC_EDGE_HI:`MTC_EDGE_LO];
  assign clear_source_select  =
    mtc_pkg::mtc_clr_t'(tcr_q[`MTC_CLR_HI:`MTC_CLR_LO]);
  // =====================================
  // Count clock
  logic [2:0] div_mask;
  logic       int_tick;
  logic       ext_now;
  logic       ext_old;
  logic       ext_tick;
  logic       tick;
  always_comb begin
    case (clock_source_select[1:0])
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end
  assign int_tick = (presc_q & div_mask) == div_mask;
  assign ext_now  = ext_clock_pin[clock_source_select[1:0]];
  assign ext_old  = ext_prev_q[clock_source_select[1:0]];
  always_comb begin
    if (external_edge_select[1]) begin
      ext_tick = ext_now ^ ext_old;
    end else if (external_edge_select[0]) begin
      ext_tick = ext_old & ~ext_now;
    end else begin
      ext_tick = ext_now & ~ext_old;
    end
  end
  // Pins sampled as synchronous, so one flop suffices
  assign tick = start_reg_q[`MTC_CH0_BIT] &
                (clock_source_select[2] ? ext_tick : int_tick);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      presc_q    <= 3'h0;
      ext_prev_q <= 4'h0;
      pa_prev_q  <= 1'b0;
      pb_prev_q  <= 1'b0;
    end else if (clk_en) begin
      presc_q    <= presc_q + 3'h1;
      ext_prev_q <= ext_clock_pin;
      pa_prev_q  <= pin_a_in;
      pb_prev_q  <= pin_b_in;
    end
  end
  // =====================================
  // Compare and capture events
  logic cmp_a;
  logic cmp_b;
  logic cap_a;
  logic cap_b;
  logic ev_a;
  logic ev_b;
  logic wrap_ev;
  logic sync_clr;
  function automatic logic cap_edge(input logic [1:0] sel,
                                    input logic now, input logic old);
    logic r;
    r = 1'b0;
    case (sel)
      2'h0:    r = now & ~old;
      2'h1:    r = old & ~now;
      2'h2:    r = now ^ old;
      default: r = 1'b0;
    endcase
    return r;
  endfunction
  assign cmp_a = tick & ~pin_control_a[2] &
                 (count_register == general_reg_a);
  assign cmp_b = tick & ~pin_control_b[2] &
                 (count_register == general_reg_b);
  assign cap_a = pin_control_a[2] &
                 cap_edge(pin_control_a[1:0], pin_a_in, pa_prev_q);
  assign cap_b = pin_control_b[2] &
                 cap_edge(pin_control_b[1:0], pin_b_in, pb_prev_q);
  assign ev_a     = cmp_a | cap_a;
  assign ev_b     = cmp_b | cap_b;
  assign wrap_ev  = tick & (count_register == `MTC_CNT_MAX);
  assign sync_clr = sync_reg_q[`MTC_CH0_BIT] &
                    (clear_source_select == mtc_pkg::MTC_CLR_SYNC) &
                    sync_clear_in;
  // =====================================
  // Bus writes
  logic wr_cnth;
  logic wr_cntl;
  assign wr_cnth = wr_en & (addr == `MTC_CNTH_OFS);
  assign wr_cntl = wr_en & (addr == `MTC_CNTL_OFS);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      start_reg_q   <= 8'h00;
      sync_reg_q    <= 8'h00;
      mode_reg_q    <= 8'h00;
      func_reg_q    <= 8'h00;
      tcr_q         <= 7'h00;
      pin_control_a <= 3'h0;
      pin_control_b <= 3'h0;
      ien_q         <= 3'h0;
    end else if (clk_en && wr_en) begin
      if (addr == `MTC_START_OFS) begin
        start_reg_q <= wdata;
      end else if (addr == `MTC_SYNC_OFS) begin
        sync_reg_q <= wdata;
      end else if (addr == `MTC_MODE_OFS) begin
        mode_reg_q <= wdata;
      end else if (addr == `MTC_FUNC_OFS) begin
        func_reg_q <= wdata;
      end else if (addr == `MTC_CTRL_OFS) begin
        tcr_q <= wdata[6:0];
      end else if (addr == `MTC_PIO_OFS) begin
        pin_control_a <= wdata[`MTC_IOA_HI:`MTC_IOA_LO];
        pin_control_b <= wdata[`MTC_IOB_HI:`MTC_IOB_LO];
      end else if (addr == `MTC_IEN_OFS) begin
        ien_q <= wdata[2:0];
      end
    end
  end
  // =====================================
  // Counter; bus write beats clear beats count
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_register <= 16'h0000;
    end else if (clk_en) begin
      if (wr_cnth) begin
        count_register[15:8] <= wdata;
      end else if (wr_cntl) begin
        count_register[7:0] <= wdata;
      end else if (sync_clr) begin
        count_register <= 16'h0000;
      end else if (ev_a &&
                   clear_source_select == mtc_pkg::MTC_CLR_A) begin
        count_register <= 16'h0000;
      end else if (ev_b &&
                   clear_source_select == mtc_pkg::MTC_CLR_B) begin
        count_register <= 16'h0000;
      end else if (tick) begin
        count_register <= count_register + 16'h0001;
      end
    end
  end
  // Clear by A or B is shared with synchronized channels
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_clear_out_q <= 1'b0;
    end else if (clk_en) begin
      sync_clear_out_q <= sync_reg_q[`MTC_CH0_BIT] & !wr_cnth & !wr_cntl &
        ((ev_a && clear_source_select == mtc_pkg::MTC_CLR_A) ||
         (ev_b && clear_source_select == mtc_pkg::MTC_CLR_B));
    end
  end
  // =====================================
  // General registers: bus write or capture
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      general_reg_a <= 16'hffff;
      general_reg_b <= 16'hffff;
    end else if (clk_en) begin
      if (wr_en && addr == `MTC_GRAH_OFS) begin
        general_reg_a[15:8] <= wdata;
      end else if (wr_en && addr == `MTC_GRAL_OFS) begin
        general_reg_a[7:0] <= wdata;
      end else if (cap_a) begin
        general_reg_a <= count_register;
      end
      if (wr_en && addr == `MTC_GRBH_OFS) begin
        general_reg_b[15:8] <= wdata;
      end else if (wr_en && addr == `MTC_GRBL_OFS) begin
        general_reg_b[7:0] <= wdata;
      end else if (cap_b) begin
        general_reg_b <= count_register;
      end
    end
  end
  // =====================================
  // Compare pin actions
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_a_out_q <= 1'b0;
      pin_a_oe_q  <= 1'b0;
    end else if (clk_en) begin
      pin_a_oe_q <= ~pin_control_a[2] & (pin_control_a[1:0] != 2'h0);
      if (cmp_a) begin
        case (pin_control_a[1:0])
          2'h1:    pin_a_out_q <= 1'b0;
          2'h2:    pin_a_out_q <= 1'b1;
          2'h3:    pin_a_out_q <= ~pin_a_out_q;
          default: pin_a_out_q <= pin_a_out_q;
        endcase
      end
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_b_out_q <= 1'b0;
      pin_b_oe_q  <= 1'b0;
    end else if (clk_en) begin
      pin_b_oe_q <= ~pin_control_b[2] & (pin_control_b[1:0] != 2'h0);
      if (cmp_b) begin
        case (pin_control_b[1:0])
          2'h1:    pin_b_out_q <= 1'b0;
          2'h2:    pin_b_out_q <= 1'b1;
          2'h3:    pin_b_out_q <= ~pin_b_out_q;
          default: pin_b_out_q <= pin_b_out_q;
        endcase
      end
    end
  end
  // =====================================
  // Status flags, set wins over write-one clear
  logic [2:0] st_set;
  logic [2:0] st_clr;
  assign st_set = {wrap_ev, ev_b, ev_a};
  assign st_clr = (wr_en && addr == `MTC_STAT_OFS) ? wdata[2:0] : 3'h0;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q  <= 3'h0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      st_q  <= (st_q & ~st_clr) | st_set;
      irq_q <= |(st_q & ien_q);
    end
  end
  // =====================================
  // Settings passed to other channels
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ch2_phase_mode_q        <= 1'b0;
      pair_combination_mode_q <= mtc_pkg::MTC_PAIR_IND0;
      channel4_sync_q         <= 1'b0;
      start_q                 <= 5'h00;
    end else if (clk_en) begin
      ch2_phase_mode_q        <= mode_reg_q[`MTC_PHASE_BIT];
      pair_combination_mode_q <= mtc_pkg::mtc_pair_t'(
        func_reg_q[`MTC_PAIR_HI:`MTC_PAIR_LO]);
      channel4_sync_q         <= sync_reg_q[`MTC_CH4_BIT];
      start_q                 <= start_reg_q[4:0];
    end
  end
  // =====================================
  // Read data, one cycle after the strobe
  logic [7:0] rd_d;
  always_comb begin
    if (addr == `MTC_START_OFS) begin
      rd_d = start_reg_q;
    end else if (addr == `MTC_SYNC_OFS) begin
      rd_d = sync_reg_q;
    end else if (addr == `MTC_MODE_OFS) begin
      rd_d = mode_reg_q;
    end else if (addr == `MTC_FUNC_OFS) begin
      rd_d = func_reg_q;
    end else if (addr == `MTC_CTRL_OFS) begin
      rd_d = `MTC_CTRL_FIX | {1'b0, tcr_q};
    end else if (addr == `MTC_PIO_OFS) begin
      rd_d = `MTC_PIO_FIX |
             {1'b0, pin_control_b, 1'b0, pin_control_a};
    end else if (addr == `MTC_IEN_OFS) begin
      rd_d = `MTC_IEN_FIX | {5'h00, ien_q};
    end else if (addr == `MTC_STAT_OFS) begin
      rd_d = `MTC_STAT_FIX | {5'h00, st_q};
    end else if (addr == `MTC_CNTH_OFS) begin
      rd_d = count_register[15:8];
    end else if (addr == `MTC_CNTL_OFS) begin
      rd_d = count_register[7:0];
    end else if (addr == `MTC_GRAH_OFS) begin
      rd_d = general_reg_a[15:8];
    end else if (addr == `MTC_GRAL_OFS) begin
      rd_d = general_reg_a[7:0];
    end else if (addr == `MTC_GRBH_OFS) begin
      rd_d = general_reg_b[15:8];
    end else if (addr == `MTC_GRBL_OFS) begin
      rd_d = general_reg_b[7:0];
    end else begin
      rd_d = 8'h00;
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= rd_en ? rd_d : 8'h00;
    end
  end
  // =====================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic quiet;
  assign quiet = clk_en & ~wr_en;
  irq_pass_a: assert property (clk_en && st_q[0] && ien_q[0] |=> irq_q)
    else $error("A match request not forwarded");
  irq_pass_b: assert property (clk_en && st_q[1] && ien_q[1] |=> irq_q)
    else $error("B match request not forwarded");
  irq_block_a: assert property (clk_en && !(|(st_q & ien_q)) |=> !irq_q)
    else $error("Masked request reached interrupt");
  wrap_flag_a: assert property (quiet && wrap_ev |=> st_q[2] and
    (clk_en && ien_q[2] |=> irq_q))
    else $error("Overflow flag or interrupt wrong");
  no_clear_a: assert property (quiet && tick &&
    clear_source_select == mtc_pkg::MTC_CLR_NONE && !sync_clr |=>
    count_register == $past(count_register) + 16'h0001)
    else $error("Counter did not advance");
  clear_on_a: assert property (quiet && ev_a &&
    clear_source_select == mtc_pkg::MTC_CLR_A |=> count_register == 16'h0000)
    else $error("Counter not cleared by A");
  clear_on_b: assert property (quiet && ev_b &&
    clear_source_select == mtc_pkg::MTC_CLR_B |=> count_register == 16'h0000)
    else $error("Counter not cleared by B");
  sync_clear_a: assert property (quiet && sync_clr |=> count_register == 16'h0000)
    else $error("Synchronous clear missed");
  toggle_pin_a: assert property (clk_en && cmp_a && pin_control_a == 3'h3 |=>
    pin_a_out_q != $past(pin_a_out_q))
    else $error("Pin A did not toggle");
  set_pin_b: assert property (clk_en && cmp_b && pin_control_b == 3'h2 |=>
    pin_b_out_q && pin_b_oe_q)
    else $error("Pin B not driven high");
  capture_a: assert property (quiet && cap_a |=>
    general_reg_a == $past(count_register))
    else $error("Capture into A wrong");
  pio_read_a: assert property (clk_en && rd_en && addr == `MTC_PIO_OFS |=>
    rdata_q[7] && rdata_q[3])
    else $error("Fixed I/O control bits not one");
  cov_match_a: cover property (cmp_a ##1 irq_q);
  cov_capture_b: cover property (cap_b ##1 st_q[1]);
  cov_overflow: cover property (wrap_ev ##[1:3] irq_q);
endmodule

//--- verification/mtc_top_tb.sv
// Self-checking bench of the channel-0 timer control block.
// Assumes mtc_top, its one-cycle register port and one clock; no partner.
`timescale 1ns/1ps
`include "mtc_cfg.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module mtc_top_tb;
  typedef struct {logic [3:0] sel; logic [15:0] val;} mtc_note_t;
  localparam logic [7:0]  RST_VAL [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h88, 8'hf8,
                                          8'hf8, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [15:0] CLR_EXP [4] = '{16'h0028, 16'h0006, 16'h0001, 16'h0000};
  localparam logic [1:0]  PIN_SEQ [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
  localparam int          LIMIT = 6000;
  logic               sys_clk, reset, clk_en, wr_en, rd_en;
  logic [7:0]         addr, wdata, rdata_q, r;
  logic [3:0]         ext_clock_pin;
  logic               pin_a_in, pin_b_in, sync_clear_in, sync_clear_out_q;
  logic               pin_a_out_q, pin_a_oe_q, pin_b_out_q, pin_b_oe_q;
  logic               ch2_phase_mode_q, channel4_sync_q, irq_q, rd_seen, pa;
  mtc_pkg::mtc_pair_t pair_combination_mode_q;
  logic [4:0]         start_q;
  logic [15:0]        v1, v2;
  int                 miscompares, checks, cycles;
  mtc_note_t          note[$];
  mtc_note_t          n;

  mtc_top i_mtc_top (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
    .ext_clock_pin(ext_clock_pin), .pin_a_in(pin_a_in), .pin_a_out_q(pin_a_out_q),
    .pin_a_oe_q(pin_a_oe_q), .pin_b_in(pin_b_in), .pin_b_out_q(pin_b_out_q),
    .pin_b_oe_q(pin_b_oe_q), .sync_clear_in(sync_clear_in),
    .sync_clear_out_q(sync_clear_out_q), .ch2_phase_mode_q(ch2_phase_mode_q),
    .pair_combination_mode_q(pair_combination_mode_q), .channel4_sync_q(channel4_sync_q),
    .start_q(start_q), .irq_q(irq_q));

  // ========================================
  // Clock
  always #2.5 sys_clk = ~sys_clk;

  // ========================================
  // Output monitor, pops the oldest note
  function automatic logic [15:0] obs(input logic [3:0] s);
    case (s)
      4'h1: obs = {15'h0, irq_q};
      4'h2: obs = {15'h0, pin_a_out_q};
      4'h3: obs = {15'h0, pin_a_oe_q};
      4'h4: obs = {15'h0, pin_b_out_q};
      4'h5: obs = {15'h0, pin_b_oe_q};
      4'h6: obs = {15'h0, ch2_phase_mode_q};
      4'h7: obs = {14'h0, pair_combination_mode_q};
      4'h8: obs = {15'h0, channel4_sync_q};
      4'h9: obs = {11'h0, start_q};
      4'ha: obs = {15'h0, sync_clear_out_q};
      default: obs = {8'h00, rdata_q};
    endcase
  endfunction

  always @(posedge sys_clk) rd_seen <= rd_en & clk_en;

  always @(posedge sys_clk) begin
    #1;
    if (rd_seen && note.size() > 0) begin
      n = note.pop_front();
      `CHK({8'h00, rdata_q}, n.val)
    end
    while (note.size() > 0 && note[0].sel != 4'h0) begin
      n = note.pop_front();
      `CHK(obs(n.sel), n.val)
    end
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      print_verdict();
    end
  end

  // ========================================
  // Bus and sequencing tasks
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // Strobes drop in the next task, so back-to-back calls assign them once
  task automatic gap(input int k);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rd_en <= 1'b0;
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wr_en <= 1'b0;
    addr <= a;
    rd_en <= 1'b1;
    note.push_back('{4'h0, {8'h00, e}});
    @(posedge sys_clk);
  endtask
  task automatic expect_out(input logic [3:0] s, input logic [15:0] e);
    note.push_back('{s, e});
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[15:8]);
    wr(a + 8'h01, d[7:0]);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] e);
    rd(a, e[15:8]);
    rd(a + 8'h01, e[7:0]);
  endtask
  // Counts for exactly win edges, so every divided rate gives a whole count
  task automatic run(input logic [7:0] ctl, input logic [7:0] pio, input int win,
                     input logic [15:0] c0);
    wr(`MTC_START_OFS, 8'h00);
    wr16(`MTC_CNTH_OFS, c0);
    wr(`MTC_CTRL_OFS, ctl);
    wr(`MTC_PIO_OFS, pio);
    wr(`MTC_START_OFS, 8'h01);
    gap(win - 1);
    wr(`MTC_START_OFS, 8'h00);
  endtask
  task automatic print_verdict();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ========================================
  // Main sequence
  initial begin
    sys_clk = 1'b0; reset = 1'b1; clk_en = 1'b1; addr = 8'h00; wdata = 8'h00;
    wr_en = 1'b0; rd_en = 1'b0; ext_clock_pin = 4'h0; pin_a_in = 1'b0; pin_b_in = 1'b0;
    sync_clear_in = 1'b0; pa = 1'b0;
    void'($urandom(48));
    cyc(2);
    reset <= 1'b0;
    foreach (RST_VAL[i]) rd(8'h60 + 8'(i), RST_VAL[i]);
    rd(8'h70, 8'h00);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom);
      wr(`MTC_FUNC_OFS, {r[7:6], 2'(i), r[3:0]});
      wr(`MTC_MODE_OFS, {r[7], i[0], r[5:0]});
      wr(`MTC_SYNC_OFS, {r[7:5], i[1], r[3:0]});
      wr(`MTC_START_OFS, r);
      gap(2);
      expect_out(4'h7, 16'(i));
      expect_out(4'h6, {15'h0, i[0]});
      expect_out(4'h8, {15'h0, i[1]});
      expect_out(4'h9, {11'h0, r[4:0]});
      wr(`MTC_CTRL_OFS, r);
      wr(`MTC_PIO_OFS, r);
      wr(`MTC_IEN_OFS, r);
      rd(`MTC_CTRL_OFS, r | 8'h80);
      rd(`MTC_PIO_OFS, r | 8'h88);
      rd(`MTC_IEN_OFS, r | 8'hf8);
    end
    wr(`MTC_IEN_OFS, 8'h00);
    wr(`MTC_SYNC_OFS, 8'h00);
    $display("test config_fields done");
    for (int d = 0; d < 4; d++) begin
      run({5'h00, 3'(d)}, 8'h00, 64, 16'h0000);
      rd16(`MTC_CNTH_OFS, 16'd64 >> d);
    end
    for (int p = 0; p < 4; p++) begin
      for (int j = 0; j < 3; j++) begin
        r = 8'($urandom);
        fork
          run({3'h0, (j == 2) ? {1'b1, r[0]} : 2'(j), 1'b1, 2'(p)}, 8'h00, 64, 16'h0000);
          begin
            cyc(8);
            for (int k = 0; k < 32; k++) begin
              ext_clock_pin <= (4'($urandom) & ~(4'h1 << p)) | (4'(k[1]) << p);
              cyc(1);
            end
            ext_clock_pin <= 4'h0;
          end
        join
        rd16(`MTC_CNTH_OFS, (j == 2) ? 16'd16 : 16'd8);
      end
    end
    fork
      run(8'h00, 8'h00, 40, 16'h0000);
      begin
        cyc(12);
        clk_en <= 1'b0;
        cyc(10);
        clk_en <= 1'b1;
      end
    join
    rd16(`MTC_CNTH_OFS, 16'd30);
    $display("test count_sources done");
    wr16(`MTC_GRAH_OFS, 16'h0010);
    wr16(`MTC_GRBH_OFS, 16'h000c);
    wr(`MTC_SYNC_OFS, 8'h01);
    sync_clear_in <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      run({1'b0, 2'(c), 5'h00}, 8'h00, 40, 16'h0000);
      rd16(`MTC_CNTH_OFS, CLR_EXP[c]);
    end
    wr(`MTC_CTRL_OFS, 8'h20);
    wr16(`MTC_CNTH_OFS, 16'h0010);
    wr(`MTC_START_OFS, 8'h01);
    gap(1);
    expect_out(4'ha, 16'h0001);
    gap(1);
    expect_out(4'ha, 16'h0000);
    wr(`MTC_START_OFS, 8'h00);
    sync_clear_in <= 1'b0;
    wr(`MTC_SYNC_OFS, 8'h00);
    $display("test clear_sources done");
    foreach (PIN_SEQ[i]) begin
      run(8'h00, {2'h0, PIN_SEQ[i], 2'h0, PIN_SEQ[i]}, 30, 16'h0000);
      pa = (PIN_SEQ[i] == 2'h1) ? 1'b0 : (PIN_SEQ[i] == 2'h2) ? 1'b1 :
           (PIN_SEQ[i] == 2'h3) ? ~pa : pa;
      expect_out(4'h2, {15'h0, pa});
      expect_out(4'h3, {15'h0, PIN_SEQ[i] != 2'h0});
      expect_out(4'h4, {15'h0, pa});
      expect_out(4'h5, {15'h0, PIN_SEQ[i] != 2'h0});
    end
    $display("test compare_pins done");
    for (int c = 4; c < 8; c++) begin
      wr(`MTC_PIO_OFS, {1'b0, 3'(c), 1'b0, 3'(c)});
      wr16(`MTC_GRAH_OFS, 16'h0000);
      wr16(`MTC_GRBH_OFS, 16'h0000);
      v1 = 16'($urandom);
      wr16(`MTC_CNTH_OFS, v1);
      pin_a_in <= 1'b1;
      pin_b_in <= 1'b1;
      gap(3);
      rd16(`MTC_GRAH_OFS, (c == 5 || c == 7) ? 16'h0000 : v1);
      rd16(`MTC_GRBH_OFS, (c == 5 || c == 7) ? 16'h0000 : v1);
      v2 = 16'($urandom);
      wr16(`MTC_CNTH_OFS, v2);
      pin_a_in <= 1'b0;
      pin_b_in <= 1'b0;
      gap(3);
      rd16(`MTC_GRAH_OFS, (c == 4) ? v1 : (c == 7) ? 16'h0000 : v2);
      rd16(`MTC_GRBH_OFS, (c == 4) ? v1 : (c == 7) ? 16'h0000 : v2);
    end
    $display("test capture_edges done");
    wr16(`MTC_GRAH_OFS, 16'h0010);
    wr16(`MTC_GRBH_OFS, 16'h000c);
    wr(`MTC_STAT_OFS, 8'h07);
    rd(`MTC_STAT_OFS, 8'hf8);
    run(8'h00, 8'h00, 4, 16'hfffe);
    rd16(`MTC_CNTH_OFS, 16'h0002);
    rd(`MTC_STAT_OFS, 8'hfc);
    expect_out(4'h1, 16'h0000);
    wr(`MTC_IEN_OFS, 8'h04);
    gap(2);
    expect_out(4'h1, 16'h0001);
    wr(`MTC_STAT_OFS, 8'h04);
    run(8'h00, 8'h00, 30, 16'h0000);
    rd(`MTC_STAT_OFS, 8'hfb);
    expect_out(4'h1, 16'h0000);
    wr(`MTC_IEN_OFS, 8'h01);
    gap(2);
    expect_out(4'h1, 16'h0001);
    wr(`MTC_STAT_OFS, 8'h01);
    gap(2);
    expect_out(4'h1, 16'h0000);
    wr(`MTC_IEN_OFS, 8'h02);
    gap(2);
    expect_out(4'h1, 16'h0001);
    wr(`MTC_STAT_OFS, 8'h02);
    gap(2);
    expect_out(4'h1, 16'h0000);
    $display("test interrupts done");
    gap(4);
    print_verdict();
  end
endmodule
